// ---- usb_out_pkg.sv ----
// Shared constants and types for the OUT endpoint control/status logic.
package usb_out_pkg;
  localparam int NUM_EP = 3;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_CSR_LOW = 8'h14;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int BIT_TOGGLE_CLR = 7;
  localparam int BIT_STALL_SENT = 6;
  localparam int BIT_STALL_REQ = 5;
  localparam int BIT_DISCARD = 4;
  localparam int BIT_RX_ERR = 3;
  localparam int BIT_LOST = 2;
  localparam int BIT_FULL = 1;
  localparam int BIT_READY = 0;
  localparam logic [1:0] PKT_NONE = 2'h0;
  localparam logic [1:0] PKT_ONE = 2'h1;
  localparam logic [1:0] PKT_TWO = 2'h2;

  typedef enum logic [2:0] {
    HS_ACK = 3'b001,
    HS_NAK = 3'b010,
    HS_STALL = 3'b100
  } hs_type;

  typedef enum logic [3:0] {
    CMD_READ = 4'h0,
    CMD_CLEAR_READY = 4'h1,
    CMD_DISCARD = 4'h2,
    CMD_STALL_ON = 4'h3,
    CMD_STALL_OFF = 4'h4,
    CMD_CLEAR_TOGGLE = 4'h5,
    CMD_CLEAR_STALL_SENT = 4'h6,
    CMD_CLEAR_LOST = 4'h7
  } cmd_type;
endpackage

// ---- usb_out_if.sv ----
// Register port between endpoint logic and the firmware agent.
`timescale 1ns/1ns
interface usb_out_if;
  import usb_out_pkg::*;
  logic [ADDR_W-1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic [1:0] ep_sel;
  logic [CNT_W-1:0] rx_count;
  logic fifo_ptr_rst;
  logic ep_irq;

  modport dev (
    input reg_addr, reg_wr, reg_rd, reg_wdata, ep_sel,
    output reg_rdata, reg_rvalid, rx_count, fifo_ptr_rst, ep_irq
  );
  modport fw (
    output reg_addr, reg_wr, reg_rd, reg_wdata, ep_sel,
    input reg_rdata, reg_rvalid, rx_count, fifo_ptr_rst, ep_irq
  );
endinterface

// ---- usb_out_ep_ctrl.sv ----
// Device end: OUT endpoint control/status byte for endpoints one to three.
`timescale 1ns/1ns
module usb_out_ep_ctrl
  import usb_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  usb_out_if.dev bus,
  input wire logic pkt_valid_i,
  input wire logic [1:0] pkt_ep_i,
  input wire logic [CNT_W-1:0] pkt_len_i,
  input wire logic pkt_err_i,
  input wire logic [NUM_EP-1:0] dbl_buf_en_i,
  input wire logic [NUM_EP-1:0] iso_mode_i,
  output logic hs_valid_o,
  output hs_type hs_code_o,
  output logic [NUM_EP-1:0] data_toggle_o
);
  logic [DATA_W-1:0] csr_w [NUM_EP];
  logic [CNT_W-1:0] len_w [NUM_EP];
  logic [NUM_EP-1:0] accept_w;
  logic [NUM_EP-1:0] lost_w;
  logic [NUM_EP-1:0] stall_w;
  logic [NUM_EP-1:0] rearm_w;
  logic [NUM_EP-1:0] ptr_rst_w;
  logic [NUM_EP-1:0] toggle_w;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++)
    begin : ep_g
      localparam logic [1:0] EP_NUM = 2'(gi + 1);
      logic [1:0] cnt_r, cnt_nxt;
      logic ready_r, ready_nxt;
      logic toggle_r, toggle_nxt;
      logic stall_sent_r, stall_sent_nxt;
      logic stall_req_r, stall_req_nxt;
      logic discard_r, discard_nxt;
      logic rx_err_r, rx_err_nxt;
      logic lost_r, lost_nxt;
      logic head_r, head_nxt;
      logic [CNT_W-1:0] len_r [2];
      logic [CNT_W-1:0] len_nxt [2];
      logic wr_hit, pkt_hit, full, accept, lost, stall, sw_clr, pop, rearm;
      logic [1:0] cap;

      always_comb
      begin
        wr_hit = bus.reg_wr && bus.reg_addr == OFS_CSR_LOW &&
                 bus.ep_sel == EP_NUM;
        pkt_hit = pkt_valid_i && pkt_ep_i == EP_NUM;
        cap = dbl_buf_en_i[gi] ? PKT_TWO : PKT_ONE;
        full = cnt_r == cap;
        stall = pkt_hit && stall_req_r;
        accept = pkt_hit && !stall_req_r && !full;
        lost = pkt_hit && !stall_req_r && full;
        sw_clr = wr_hit && !bus.reg_wdata[BIT_READY] && ready_r;
        pop = sw_clr || (discard_r && ready_r);
        rearm = !ready_r && cnt_r != PKT_NONE && !discard_r;
        cnt_nxt = cnt_r;
        if (accept)
          cnt_nxt = cnt_nxt + PKT_ONE;
        if (pop)
          cnt_nxt = cnt_nxt - PKT_ONE;
        head_nxt = pop ? !head_r : head_r;
        len_nxt = len_r;
        if (accept)
          len_nxt[head_r ^ (cnt_r != PKT_NONE)] = pkt_len_i;
        ready_nxt = ready_r;
        if (pop)
          ready_nxt = 1'b0;
        else if (rearm)
          ready_nxt = 1'b1;
        // Discard holds one cycle so a write never races the pointer reset.
        discard_nxt = wr_hit ? bus.reg_wdata[BIT_DISCARD] : 1'b0;
        stall_req_nxt = wr_hit ? bus.reg_wdata[BIT_STALL_REQ] : stall_req_r;
        stall_sent_nxt = stall_sent_r;
        if (wr_hit && !bus.reg_wdata[BIT_STALL_SENT])
          stall_sent_nxt = 1'b0;
        if (stall)
          stall_sent_nxt = 1'b1;
        lost_nxt = lost_r;
        if (wr_hit && !bus.reg_wdata[BIT_LOST])
          lost_nxt = 1'b0;
        if (lost && iso_mode_i[gi])
          lost_nxt = 1'b1;
        rx_err_nxt = rx_err_r;
        if (sw_clr)
          rx_err_nxt = 1'b0;
        if (accept && pkt_err_i && iso_mode_i[gi])
          rx_err_nxt = 1'b1;
        toggle_nxt = accept ? !toggle_r : toggle_r;
        if (wr_hit && bus.reg_wdata[BIT_TOGGLE_CLR])
          toggle_nxt = 1'b0;
      end

      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          cnt_r <= PKT_NONE;
          ready_r <= 1'b0;
          toggle_r <= 1'b0;
          stall_sent_r <= 1'b0;
          stall_req_r <= 1'b0;
          discard_r <= 1'b0;
          rx_err_r <= 1'b0;
          lost_r <= 1'b0;
          head_r <= 1'b0;
          len_r[0] <= '0;
          len_r[1] <= '0;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          ready_r <= ready_nxt;
          toggle_r <= toggle_nxt;
          stall_sent_r <= stall_sent_nxt;
          stall_req_r <= stall_req_nxt;
          discard_r <= discard_nxt;
          rx_err_r <= rx_err_nxt;
          lost_r <= lost_nxt;
          head_r <= head_nxt;
          len_r <= len_nxt;
        end
      end

      // The toggle-clear position always reads back as zero.
      assign csr_w[gi] = {1'b0, stall_sent_r, stall_req_r, discard_r,
                          rx_err_r, lost_r, full, ready_r};
      assign len_w[gi] = len_r[head_r];
      assign accept_w[gi] = accept;
      assign lost_w[gi] = lost;
      assign stall_w[gi] = stall;
      assign rearm_w[gi] = rearm;
      assign ptr_rst_w[gi] = discard_r;
      assign toggle_w[gi] = toggle_r;
    end
  endgenerate

  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic ptr_rst_r, ptr_rst_nxt;
  logic irq_r, irq_nxt;
  logic hs_valid_r, hs_valid_nxt;
  hs_type hs_code_r, hs_code_nxt;
  logic [NUM_EP-1:0] toggle_r;
  logic sel_ok;
  logic [1:0] sel_idx;
  logic pkt_iso;
  logic [1:0] pkt_idx;

  always_comb
  begin
    sel_ok = bus.ep_sel != 2'h0;
    sel_idx = bus.ep_sel - 2'h1;
    pkt_idx = pkt_ep_i - 2'h1;
    pkt_iso = pkt_ep_i != 2'h0 && iso_mode_i[pkt_idx];
    rvalid_nxt = bus.reg_rd;
    rdata_nxt = '0;
    if (bus.reg_rd && sel_ok && bus.reg_addr == OFS_CSR_LOW)
      rdata_nxt = csr_w[sel_idx];
    count_nxt = sel_ok ? len_w[sel_idx] : '0;
    ptr_rst_nxt = |ptr_rst_w;
    irq_nxt = |(stall_w | rearm_w | (lost_w & iso_mode_i));
    hs_valid_nxt = 1'b0;
    hs_code_nxt = HS_ACK;
    if (|stall_w)
    begin
      hs_valid_nxt = 1'b1;
      hs_code_nxt = HS_STALL;
    end
    else if (|lost_w && !pkt_iso)
    begin
      hs_valid_nxt = 1'b1;
      hs_code_nxt = HS_NAK;
    end
    else if (|accept_w && !pkt_iso)
      hs_valid_nxt = 1'b1;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_r <= CSR_RESET;
      rvalid_r <= 1'b0;
      count_r <= '0;
      ptr_rst_r <= 1'b0;
      irq_r <= 1'b0;
      hs_valid_r <= 1'b0;
      hs_code_r <= HS_ACK;
      toggle_r <= '0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      count_r <= count_nxt;
      ptr_rst_r <= ptr_rst_nxt;
      irq_r <= irq_nxt;
      hs_valid_r <= hs_valid_nxt;
      hs_code_r <= hs_code_nxt;
      toggle_r <= toggle_w;
    end
  end

  assign bus.reg_rdata = rdata_r;
  assign bus.reg_rvalid = rvalid_r;
  assign bus.rx_count = count_r;
  assign bus.fifo_ptr_rst = ptr_rst_r;
  assign bus.ep_irq = irq_r;
  assign hs_valid_o = hs_valid_r;
  assign hs_code_o = hs_code_r;
  assign data_toggle_o = toggle_r;
endmodule

// ---- usb_out_fw_agent.sv ----
// Firmware end: turns simple commands into control/status byte accesses.
`timescale 1ns/1ns
module usb_out_fw_agent
  import usb_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  usb_out_if.fw bus,
  input wire logic cmd_valid_i,
  input cmd_type cmd_code_i,
  input wire logic [1:0] cmd_ep_i,
  input wire logic byte_read_i,
  output logic cmd_ready_o,
  output logic [DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic refused_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_POLL = 4'b0100,
    ST_DONE = 4'b1000
  } state_type;

  state_type state_r, state_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [1:0] ep_r, ep_nxt;
  logic [NUM_EP-1:0] stall_sh_r, stall_sh_nxt;
  logic partial_r, partial_nxt;
  logic ready_r, ready_nxt;
  logic [DATA_W-1:0] rdo_r, rdo_nxt;
  logic rdv_r, rdv_nxt;
  logic refused_r, refused_nxt;
  logic discard_r, discard_nxt;
  logic [DATA_W-1:0] keep;
  logic [1:0] idx;

  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = OFS_CSR_LOW;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    wdata_nxt = wdata_r;
    ep_nxt = ep_r;
    stall_sh_nxt = stall_sh_r;
    partial_nxt = partial_r || byte_read_i;
    ready_nxt = ready_r;
    rdo_nxt = rdo_r;
    rdv_nxt = 1'b0;
    refused_nxt = 1'b0;
    discard_nxt = discard_r;
    idx = cmd_ep_i - 2'h1;
    // Writing ones to the sticky bits and ready leaves them untouched.
    keep = '0;
    keep[BIT_STALL_SENT] = 1'b1;
    keep[BIT_LOST] = 1'b1;
    keep[BIT_READY] = 1'b1;
    keep[BIT_STALL_REQ] = stall_sh_r[idx];
    unique case (state_r)
      ST_IDLE:
        if (cmd_valid_i && cmd_ep_i != 2'h0)
        begin
          ep_nxt = cmd_ep_i;
          wdata_nxt = keep;
          discard_nxt = 1'b0;
          ready_nxt = 1'b0;
          state_nxt = ST_WAIT;
          wr_nxt = 1'b1;
          unique case (cmd_code_i)
            CMD_READ:
            begin
              wr_nxt = 1'b0;
              rd_nxt = 1'b1;
            end
            CMD_CLEAR_READY:
            begin
              wdata_nxt[BIT_READY] = 1'b0;
              partial_nxt = 1'b0;
            end
            CMD_DISCARD:
              if (partial_r)
              begin
                wr_nxt = 1'b0;
                refused_nxt = 1'b1;
                state_nxt = ST_DONE;
              end
              else
              begin
                wdata_nxt[BIT_DISCARD] = 1'b1;
                discard_nxt = 1'b1;
              end
            CMD_STALL_ON:
            begin
              wdata_nxt[BIT_STALL_REQ] = 1'b1;
              stall_sh_nxt[idx] = 1'b1;
            end
            CMD_STALL_OFF:
            begin
              wdata_nxt[BIT_STALL_REQ] = 1'b0;
              stall_sh_nxt[idx] = 1'b0;
            end
            CMD_CLEAR_TOGGLE:
              wdata_nxt[BIT_TOGGLE_CLR] = 1'b1;
            CMD_CLEAR_STALL_SENT:
              wdata_nxt[BIT_STALL_SENT] = 1'b0;
            CMD_CLEAR_LOST:
              wdata_nxt[BIT_LOST] = 1'b0;
            default:
            begin
              wr_nxt = 1'b0;
              refused_nxt = 1'b1;
              state_nxt = ST_DONE;
            end
          endcase
        end
      ST_WAIT:
        if (!discard_r)
          state_nxt = rd_r ? ST_POLL : ST_DONE;
        else
        begin
          rd_nxt = 1'b1;
          state_nxt = ST_POLL;
        end
      ST_POLL:
        if (bus.reg_rvalid)
        begin
          if (discard_r && bus.reg_rdata[BIT_DISCARD])
          begin
            rd_nxt = 1'b1;
          end
          else
          begin
            rdo_nxt = bus.reg_rdata;
            rdv_nxt = !discard_r;
            partial_nxt = discard_r ? 1'b0 : partial_nxt;
            state_nxt = ST_DONE;
          end
        end
      ST_DONE:
      begin
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_IDLE;
      addr_r <= OFS_CSR_LOW;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      wdata_r <= CSR_RESET;
      ep_r <= 2'h0;
      stall_sh_r <= '0;
      partial_r <= 1'b0;
      ready_r <= 1'b1;
      rdo_r <= '0;
      rdv_r <= 1'b0;
      refused_r <= 1'b0;
      discard_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      wdata_r <= wdata_nxt;
      ep_r <= ep_nxt;
      stall_sh_r <= stall_sh_nxt;
      partial_r <= partial_nxt;
      ready_r <= ready_nxt;
      rdo_r <= rdo_nxt;
      rdv_r <= rdv_nxt;
      refused_r <= refused_nxt;
      discard_r <= discard_nxt;
    end
  end

  assign bus.reg_addr = addr_r;
  assign bus.reg_wr = wr_r;
  assign bus.reg_rd = rd_r;
  assign bus.reg_wdata = wdata_r;
  assign bus.ep_sel = ep_r;
  assign cmd_ready_o = ready_r;
  assign rd_data_o = rdo_r;
  assign rd_valid_o = rdv_r;
  assign refused_o = refused_r;
endmodule

// ---- usb_out_props.sv ----
// Checker for the register side of the OUT endpoint link.
`timescale 1ns/1ns
module usb_out_props
  import usb_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [1:0] ep_sel,
  input wire logic fifo_ptr_rst
);
  logic hit;
  logic disc_w;
  logic [3:0] stall_r;
  logic [3:0] stall_nxt;
  assign hit = (reg_addr == OFS_CSR_LOW) && (ep_sel != 2'h0);
  assign disc_w = reg_wr && hit && reg_wdata[BIT_DISCARD];
  // Shadow of the stall request per endpoint, as last written.
  always_comb
  begin
    stall_nxt = stall_r;
    if (reg_wr && hit)
    begin
      stall_nxt[ep_sel] = reg_wdata[BIT_STALL_REQ];
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stall_r <= 4'h0;
    end
    else
    begin
      stall_r <= stall_nxt;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd_hit;
    reg_rd && hit;
  endsequence
  sequence s_answer;
    ##1 reg_rvalid;
  endsequence
  AST_RVALID_ON_RD: assert property (reg_rd |-> s_answer)
    else $error("read strobe got no answer");
  AST_RVALID_ONLY_RD: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without a read strobe");
  AST_TOGGLE_READS_ZERO: assert property (
    reg_rvalid |-> !reg_rdata[BIT_TOGGLE_CLR])
    else $error("toggle clear bit read as one");
  AST_UNMAPPED_ZERO: assert property (
    reg_rd && !hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_STALL_READBACK: assert property (
    s_rd_hit |=> reg_rdata[BIT_STALL_REQ] == $past(stall_r[ep_sel]))
    else $error("stall request readback wrong");
  AST_PTR_RST_CAUSE: assert property (
    fifo_ptr_rst |-> $past(disc_w) || $past(disc_w, 2) || $past(disc_w, 3))
    else $error("pointer reset without discard");
  AST_PTR_RST_PULSE: assert property (
    fifo_ptr_rst |=> !fifo_ptr_rst)
    else $error("pointer reset longer than a pulse");
  AST_DISCARD_BRIEF: assert property (
    reg_rvalid && reg_rdata[BIT_DISCARD] |->
      $past(disc_w) || $past(disc_w, 2) || $past(disc_w, 3))
    else $error("discard bit did not clear itself");
endmodule

// ---- usb_out_endpoint_ctrl_status_tb_top.sv ----
// Self-checking bench joining both ends of the OUT endpoint link.
`timescale 1ns/1ns
module usb_out_endpoint_ctrl_status_tb_top
  import usb_out_pkg::*;
;
  logic clk_i;
  logic sys_rst_i;
  logic pkt_valid_i;
  logic [1:0] pkt_ep_i;
  logic [CNT_W-1:0] pkt_len_i;
  logic pkt_err_i;
  logic [NUM_EP-1:0] dbl_buf_en_i;
  logic [NUM_EP-1:0] iso_mode_i;
  logic hs_valid_o;
  hs_type hs_code_o;
  logic [NUM_EP-1:0] data_toggle_o;
  logic cmd_valid_i;
  cmd_type cmd_code_i;
  logic [1:0] cmd_ep_i;
  logic byte_read_i;
  logic cmd_ready_o;
  logic [DATA_W-1:0] rd_data_o;
  logic rd_valid_o;
  logic refused_o;
  int err_total;
  int checks;
  int cycles;
  int irq_n;
  int ptr_n;
  int ref_n;
  logic [31:0] seed;
  logic [DATA_W-1:0] exp_rd[$];
  hs_type exp_hs[$];
  usb_out_if bus_if();
  usb_out_ep_ctrl u_usb_out_ep_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .bus(bus_if.dev), .pkt_valid_i(pkt_valid_i), .pkt_ep_i(pkt_ep_i),
    .pkt_len_i(pkt_len_i), .pkt_err_i(pkt_err_i),
    .dbl_buf_en_i(dbl_buf_en_i), .iso_mode_i(iso_mode_i),
    .hs_valid_o(hs_valid_o), .hs_code_o(hs_code_o),
    .data_toggle_o(data_toggle_o));
  usb_out_fw_agent u_usb_out_fw_agent (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .bus(bus_if.fw), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_ep_i(cmd_ep_i),
    .byte_read_i(byte_read_i), .cmd_ready_o(cmd_ready_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .refused_o(refused_o));
  usb_out_props u_usb_out_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr(bus_if.reg_addr), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_wdata(bus_if.reg_wdata),
    .reg_rdata(bus_if.reg_rdata), .reg_rvalid(bus_if.reg_rvalid),
    .ep_sel(bus_if.ep_sel), .fifo_ptr_rst(bus_if.fifo_ptr_rst));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [CNT_W-1:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[CNT_W-1:0];
  endfunction
  task automatic chk(string nm, logic [CNT_W-1:0] e, logic [CNT_W-1:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Commands are held one cycle past the falling edge that shows the agent ready.
  task automatic cmd(cmd_type c, logic [1:0] ep);
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    cmd_ep_i = ep;
    while (cmd_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    while (cmd_ready_o !== 1'b1) @(negedge clk_i);
  endtask
  task automatic rd(logic [1:0] ep, logic [DATA_W-1:0] e);
    exp_rd.push_back(e);
    cmd(CMD_READ, ep);
  endtask
  // A zero handshake code means no handshake is due.
  task automatic pkt(logic [1:0] ep, logic [CNT_W-1:0] n, logic er,
    logic [2:0] h);
    if (h != 3'h0)
      exp_hs.push_back(hs_type'(h));
    pkt_valid_i = 1'b1;
    pkt_ep_i = ep;
    pkt_len_i = n;
    pkt_err_i = er;
    @(negedge clk_i);
    pkt_valid_i = 1'b0;
    pkt_len_i = ~n;
    repeat (5) @(negedge clk_i);
  endtask
  always @(negedge clk_i)
  begin
    if (rd_valid_o === 1'b1)
      chk("rd_data", exp_rd.size() ? exp_rd.pop_front() : 'x, rd_data_o);
    if (hs_valid_o === 1'b1)
      chk("hs_code", exp_hs.size() ? exp_hs.pop_front() : 'x, hs_code_o);
    if (bus_if.ep_irq === 1'b1)
      irq_n++;
    if (bus_if.fifo_ptr_rst === 1'b1)
      ptr_n++;
    if (refused_o === 1'b1)
      ref_n++;
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    logic [CNT_W-1:0] n;
    logic [CNT_W-1:0] m;
    seed = 32'h0000_9b44;
    {pkt_valid_i, pkt_ep_i, pkt_len_i, pkt_err_i, iso_mode_i} = '0;
    {cmd_valid_i, cmd_ep_i, byte_read_i} = '0;
    dbl_buf_en_i = 3'h2;
    cmd_code_i = CMD_READ;
    sys_rst_i = 1'b1;
    repeat (16) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    for (int e = 1; e <= 3; e++)
      rd(e[1:0], CSR_RESET);
    n = rnd();
    pkt(2'h1, n, 1'b0, HS_ACK);
    rd(2'h1, 8'h03);
    chk("count", n, bus_if.rx_count);
    chk("irq", 10'd1, 10'(irq_n));
    pkt(2'h1, rnd(), 1'b0, HS_NAK);
    cmd(CMD_CLEAR_READY, 2'h1);
    rd(2'h1, 8'h00);
    n = rnd();
    m = rnd();
    pkt(2'h2, n, 1'b0, HS_ACK);
    pkt(2'h2, m, 1'b0, HS_ACK);
    rd(2'h2, 8'h03);
    chk("count", n, bus_if.rx_count);
    cmd(CMD_CLEAR_READY, 2'h2);
    rd(2'h2, 8'h01);
    chk("irq", 10'd3, 10'(irq_n));
    n = rnd();
    pkt(2'h2, n, 1'b0, HS_ACK);
    cmd(CMD_DISCARD, 2'h2);
    rd(2'h2, 8'h01);
    chk("count", n, bus_if.rx_count);
    cmd(CMD_DISCARD, 2'h2);
    rd(2'h2, 8'h00);
    chk("ptr_rst", 10'd2, 10'(ptr_n));
    pkt(2'h2, rnd(), 1'b0, HS_ACK);
    byte_read_i = 1'b1;
    @(negedge clk_i);
    byte_read_i = 1'b0;
    cmd(CMD_DISCARD, 2'h2);
    chk("refused", 10'd1, 10'(ref_n));
    rd(2'h2, 8'h01);
    cmd(CMD_CLEAR_READY, 2'h2);
    cmd(CMD_STALL_ON, 2'h3);
    m = 10'(irq_n);
    pkt(2'h3, rnd(), 1'b0, HS_STALL);
    rd(2'h3, 8'h60);
    chk("irq", m + 10'd1, 10'(irq_n));
    cmd(CMD_CLEAR_STALL_SENT, 2'h3);
    rd(2'h3, 8'h20);
    cmd(CMD_STALL_OFF, 2'h3);
    pkt(2'h3, rnd(), 1'b0, HS_ACK);
    chk("toggle", 10'd1, 10'(data_toggle_o[2]));
    cmd(CMD_CLEAR_TOGGLE, 2'h3);
    chk("toggle", 10'd0, 10'(data_toggle_o[2]));
    rd(2'h3, 8'h03);
    cmd(CMD_CLEAR_READY, 2'h3);
    iso_mode_i = 3'h1;
    pkt(2'h1, rnd(), 1'b1, 3'h0);
    rd(2'h1, 8'h0b);
    m = 10'(irq_n);
    pkt(2'h1, rnd(), 1'b0, 3'h0);
    chk("irq", m + 10'd1, 10'(irq_n));
    rd(2'h1, 8'h0f);
    cmd(CMD_CLEAR_LOST, 2'h1);
    rd(2'h1, 8'h0b);
    cmd(CMD_CLEAR_READY, 2'h1);
    rd(2'h1, 8'h00);
    repeat (4) @(negedge clk_i);
    // A note still queued means a read or handshake never showed up.
    chk("left", 10'd0, 10'(exp_rd.size() + exp_hs.size()));
    test_done();
  end
endmodule
